// *** rtl/uied_pkg.sv ***
package uied_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register word indices (Avalon word address)
    localparam logic [15:0] EP0_IN_CFG_IDX  = 16'hff80;
    localparam logic [15:0] EP0_IN_CNT_IDX  = 16'hff81;
    localparam logic [15:0] EP0_OUT_CFG_IDX = 16'hff82;
    localparam logic [15:0] EP0_OUT_CNT_IDX = 16'hff83;
    localparam logic [15:0] IRQ_STATUS_IDX  = 16'hff90;
    localparam logic [15:0] IRQ_CLEAR_IDX   = 16'hff91;
    localparam logic [15:0] IRQ_ENABLE_IDX  = 16'hff92;

    // Descriptor entry offsets inside one 8-entry block
    localparam logic [2:0]  OFS_CFG   = 3'h0;
    localparam logic [2:0]  OFS_XBASE = 3'h1;
    localparam logic [2:0]  OFS_XCNT  = 3'h2;
    localparam logic [2:0]  OFS_YBASE = 3'h5;
    localparam logic [2:0]  OFS_YCNT  = 3'h6;
    localparam logic [2:0]  OFS_SIZE  = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_EN    = 7;
    localparam int BIT_TOG   = 5;
    localparam int BIT_DOUBLE_BUFFER_ENABLE  = 4;
    localparam int BIT_STALL = 3;
    localparam int BIT_IE    = 2;
    localparam int BIT_NAK   = 7;

    // Reset values and writable masks of the endpoint 0 registers, and the descriptor reset value
    localparam logic [7:0]  EP0_CFG_RST   = 8'h00;
    localparam logic [7:0]  EP0_CNT_RST   = 8'h80;
    localparam logic [7:0]  EP0_CFG_WMASK = 8'h8c;
    localparam logic [7:0]  EP0_CNT_WMASK = 8'h8f;
    localparam logic [7:0]  DESC_RST      = 8'h00;

    // Endpoint 0 fixed buffers and packet limit
    localparam logic [15:0] EP0_IN_BUF  = 16'hfef8;
    localparam logic [15:0] EP0_OUT_BUF = 16'hfef0;
    localparam logic [3:0]  EP0_MAX     = 4'h8;

    // Buffer choice: Y only with double buffering and toggle set
    function automatic logic uied_pick_y(input logic [7:0] cfg);
        return cfg[BIT_DOUBLE_BUFFER_ENABLE] & cfg[BIT_TOG];
    endfunction

endpackage

// *** rtl/uied_lk_if.sv ***
`timescale 1ns/100ps
interface uied_lk_if;
    logic        req;
    logic [1:0]  ep;
    logic [7:0]  cfg;
    logic [7:0]  xcnt;
    logic [7:0]  ycnt;
    logic [7:0]  xbase;
    logic [7:0]  ybase;
    logic [7:0]  size;
    logic        valid;
    logic        serve;
    logic        use_y;
    logic        nak;
    logic [6:0]  count;
    logic [6:0]  sz;
    logic [15:0] start;

    modport main   (output req, ep, cfg, xcnt, ycnt, xbase, ybase, size,
                    input  valid, serve, use_y, nak, count, sz, start);
    modport lookup (input  req, ep, cfg, xcnt, ycnt, xbase, ybase, size,
                    output valid, serve, use_y, nak, count, sz, start);
endinterface

// *** rtl/uied_lookup.sv ***
`timescale 1ns/100ps
module uied_lookup (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Descriptor view
    uied_lk_if.lookup lk
);
    import uied_pkg::*;

    logic       sel_y;
    logic [7:0] cnt;
    logic [7:0] base;

    ////////////////////////////////////////////////////////////////////////////
    // Pick X or Y entries of the requested endpoint
    assign sel_y = uied_pick_y(lk.cfg);
    assign cnt   = sel_y ? lk.ycnt : lk.xcnt;
    assign base  = sel_y ? lk.ybase : lk.xbase;

    ////////////////////////////////////////////////////////////////////////////
    // Registered answer, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lk.valid <= 1'b0;
            lk.serve <= 1'b0;
            lk.use_y <= 1'b0;
            lk.nak   <= 1'b1;
            lk.count <= 7'h00;
            lk.sz    <= 7'h00;
            lk.start <= 16'h0000;
        end else begin
            lk.valid <= lk.req;
            if (lk.req) begin
                lk.serve <= lk.cfg[BIT_EN];
                lk.nak   <= cnt[BIT_NAK];
                if (lk.ep == 2'h0) begin
                    // Fixed buffer, counts above eight read as eight
                    lk.use_y <= 1'b0;
                    lk.start <= EP0_IN_BUF;
                    lk.count <= (cnt[3:0] > EP0_MAX) ? {3'h0, EP0_MAX} : {3'h0, cnt[3:0]};
                    lk.sz    <= {3'h0, EP0_MAX};
                end else begin
                    lk.use_y <= sel_y;
                    lk.start <= {5'h00, base, 3'h0};
                    lk.count <= cnt[6:0];
                    lk.sz    <= lk.size[6:0];
                end
            end
        end
    end
endmodule

// *** rtl/uied_irq.sv ***
`timescale 1ns/100ps
module uied_irq (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Events
    input  wire logic [3:0] set,
    // Software access
    input  wire logic       clr_we,
    input  wire logic       en_we,
    input  wire logic [3:0] wdata,
    // State
    output logic      [3:0] status,
    output logic      [3:0] enable,
    output logic            irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Sticky status, a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= 4'h0;
        end else begin
            status <= (status & ~(clr_we ? wdata : 4'h0)) | set;
        end
    end

    // Enable mask
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            enable <= 4'h0;
        end else if (en_we) begin
            enable <= wdata;
        end
    end

    // Level interrupt
    assign irq = |(status & enable);
endmodule

// *** rtl/uied_top.sv ***
`timescale 1ns/100ps
module uied_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [15:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Buffer manager lookup
    input  wire logic        bm_req,
    input  wire logic [1:0]  bm_ep,
    output logic             bm_valid,
    output logic             bm_serve,
    output logic             bm_use_y,
    output logic             bm_nak,
    output logic      [6:0]  bm_count,
    output logic      [6:0]  bm_size,
    output logic      [15:0] bm_start,
    // Buffer manager completion
    input  wire logic        bm_done,
    input  wire logic [1:0]  bm_done_ep,
    // Interrupt
    output logic             irq
);
    import uied_pkg::*;

    logic [7:0]  desc [0:31];
    logic [7:0]  ctrl_in_config;
    logic [7:0]  ctrl_in_count;
    logic [7:0]  ctrl_out_config;
    logic [7:0]  ctrl_out_count;
    logic        rd_ack;
    logic        wr_lo;
    logic        desc_hit;
    logic [4:0]  idx;
    logic [31:0] rd_val;
    logic [7:0]  done_cfg;
    logic        done_ok;
    logic [3:0]  irq_set;
    logic [3:0]  irq_status;
    logic [3:0]  irq_enable;

    uied_lk_if lk ();

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign wr_lo    = avs_write & avs_byteenable[0];
    assign idx      = avs_address[4:0];
    assign desc_hit = (avs_address[15:5] == 11'h000) && (avs_address[4:3] != 2'h0);

    // Reads wait one cycle, writes complete at once
    assign avs_waitrequest = avs_read & ~rd_ack;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= avs_read & ~rd_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Completion side: configuration of the finishing endpoint
    always_comb begin
        done_cfg = ctrl_in_config;
        if (bm_done_ep != 2'h0) begin
            done_cfg = desc[{bm_done_ep, OFS_CFG}];
        end
    end

    assign done_ok = bm_done & done_cfg[BIT_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor memory for endpoints 1 to 3, firmware writes, then completion
    // marks the used buffer empty and flips the toggle; base entries untouched
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) begin
                desc[i] <= DESC_RST;
            end
        end else begin
            if (wr_lo && desc_hit) begin
                desc[idx] <= avs_writedata[7:0];
            end
            if (done_ok && bm_done_ep != 2'h0) begin
                if (uied_pick_y(done_cfg)) begin
                    desc[{bm_done_ep, OFS_YCNT}][BIT_NAK] <= 1'b1;
                end else begin
                    desc[{bm_done_ep, OFS_XCNT}][BIT_NAK] <= 1'b1;
                end
                desc[{bm_done_ep, OFS_CFG}][BIT_TOG] <= ~done_cfg[BIT_TOG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Endpoint 0 input configuration, toggle is hardware-owned
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_in_config <= EP0_CFG_RST;
        end else begin
            if (wr_lo && avs_address == EP0_IN_CFG_IDX) begin
                ctrl_in_config <= (ctrl_in_config & ~EP0_CFG_WMASK) | (avs_writedata[7:0] & EP0_CFG_WMASK);
            end
            if (done_ok && bm_done_ep == 2'h0) begin
                ctrl_in_config[BIT_TOG] <= ~ctrl_in_config[BIT_TOG];
            end
        end
    end

    // Endpoint 0 input count, completion marks it empty
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_in_count <= EP0_CNT_RST;
        end else begin
            if (wr_lo && avs_address == EP0_IN_CNT_IDX) begin
                ctrl_in_count <= avs_writedata[7:0] & EP0_CNT_WMASK;
            end
            if (done_ok && bm_done_ep == 2'h0) begin
                ctrl_in_count[BIT_NAK] <= 1'b1;
            end
        end
    end

    // Endpoint 0 output registers, same layout as the input pair
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_out_config <= EP0_CFG_RST;
            ctrl_out_count  <= EP0_CNT_RST;
        end else begin
            if (wr_lo && avs_address == EP0_OUT_CFG_IDX) begin
                ctrl_out_config <= (ctrl_out_config & ~EP0_CFG_WMASK) | (avs_writedata[7:0] & EP0_CFG_WMASK);
            end
            if (wr_lo && avs_address == EP0_OUT_CNT_IDX) begin
                ctrl_out_count <= avs_writedata[7:0] & EP0_CNT_WMASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer, unmapped words read zero
    always_comb begin
        rd_val = 32'h0000_0000;
        if (desc_hit) begin
            rd_val[7:0] = desc[idx];
        end else begin
            case (avs_address)
                EP0_IN_CFG_IDX:  rd_val[7:0] = ctrl_in_config;
                EP0_IN_CNT_IDX:  rd_val[7:0] = ctrl_in_count;
                EP0_OUT_CFG_IDX: rd_val[7:0] = ctrl_out_config;
                EP0_OUT_CNT_IDX: rd_val[7:0] = ctrl_out_count;
                IRQ_STATUS_IDX:  rd_val[3:0] = irq_status;
                IRQ_ENABLE_IDX:  rd_val[3:0] = irq_enable;
                default:         rd_val = 32'h0000_0000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !rd_ack) begin
            avs_readdata <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Feed the lookup with the requested endpoint's entries
    always_comb begin
        lk.req   = bm_req;
        lk.ep    = bm_ep;
        lk.cfg   = ctrl_in_config;
        lk.xcnt  = ctrl_in_count;
        lk.ycnt  = ctrl_in_count;
        lk.xbase = 8'h00;
        lk.ybase = 8'h00;
        lk.size  = 8'h00;
        if (bm_ep != 2'h0) begin
            lk.cfg   = desc[{bm_ep, OFS_CFG}];
            lk.xcnt  = desc[{bm_ep, OFS_XCNT}];
            lk.ycnt  = desc[{bm_ep, OFS_YCNT}];
            lk.xbase = desc[{bm_ep, OFS_XBASE}];
            lk.ybase = desc[{bm_ep, OFS_YBASE}];
            lk.size  = desc[{bm_ep, OFS_SIZE}];
        end
    end

    uied_lookup u_lookup (
        .clk_sys (clk_sys),
        .rst     (rst),
        .lk      (lk)
    );

    assign bm_valid = lk.valid;
    assign bm_serve = lk.serve;
    assign bm_use_y = lk.use_y;
    assign bm_nak   = lk.nak;
    assign bm_count = lk.count;
    assign bm_size  = lk.sz;
    assign bm_start = lk.start;

    ////////////////////////////////////////////////////////////////////////////
    // Completion events gated by the endpoint interrupt enable
    always_comb begin
        irq_set = 4'h0;
        irq_set[bm_done_ep] = done_ok & done_cfg[BIT_IE];
    end

    uied_irq u_irq (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set     (irq_set),
        .clr_we  (wr_lo && avs_address == IRQ_CLEAR_IDX),
        .en_we   (wr_lo && avs_address == IRQ_ENABLE_IDX),
        .wdata   (avs_writedata[3:0]),
        .status  (irq_status),
        .enable  (irq_enable),
        .irq     (irq)
    );

endmodule

// *** tb/uied_assertions.sv ***
`timescale 1ns/100ps
module uied_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Register bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    // Lookup
    input wire logic        bm_req,
    input wire logic [1:0]  bm_ep,
    input wire logic        bm_valid,
    input wire logic        bm_use_y,
    input wire logic [6:0]  bm_count,
    input wire logic [6:0]  bm_size,
    input wire logic [15:0] bm_start
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////
    // Lookup answers and fixed endpoint 0 view
    chk_valid_after: assert property (bm_req |=> bm_valid) else $error("no answer to lookup");
    chk_valid_cause: assert property (bm_valid |-> $past(bm_req)) else $error("answer without lookup");
    chk_start_align: assert property (bm_valid && $past(bm_ep) != 2'h0
        |-> bm_start[15:11] == 5'h00 && bm_start[2:0] == 3'h0) else $error("start not aligned");
    chk_ep0_start: assert property (bm_valid && $past(bm_ep) == 2'h0
        |-> bm_start == 16'hfef8) else $error("endpoint 0 start wrong");
    chk_ep0_single: assert property (bm_valid && $past(bm_ep) == 2'h0
        |-> !bm_use_y && bm_size == 7'h08 && bm_count <= 7'h08) else $error("endpoint 0 fields wrong");
    chk_fields_hold: assert property (!$past(bm_req)
        |-> $stable(bm_start) && $stable(bm_count)) else $error("fields moved without lookup");

    // Register bus timing
    chk_wr_nowait: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
    chk_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read not held");
    chk_rd_answer: assert property (avs_read && avs_waitrequest
        |=> !avs_waitrequest) else $error("read answer late");
endmodule

bind uied_top uied_checker i_uied_checker (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest,
    .bm_req, .bm_ep, .bm_valid, .bm_use_y, .bm_count, .bm_size, .bm_start);

// *** tb/uied_bm_model.sv ***
`timescale 1ns/100ps
module uied_bm_model (
    // Clock
    input wire logic       clk_sys,
    // Lookup and completion
    output logic           bm_req,
    output logic     [1:0] bm_ep,
    output logic           bm_done,
    output logic     [1:0] bm_done_ep
);
    // Idle at time zero
    initial begin
        bm_req     = 1'b0;
        bm_ep      = 2'h0;
        bm_done    = 1'b0;
        bm_done_ep = 2'h0;
    end

    // One lookup after gap plus one idle cycles; returns in the answer cycle
    task automatic lookup(input logic [1:0] ep, input int gap);
        repeat (gap + 1) @(posedge clk_sys);
        bm_req <= 1'b1;
        bm_ep  <= ep;
        @(posedge clk_sys);
        bm_req <= 1'b0;
        bm_ep  <= ~ep;
        #1;
    endtask

    // One completion pulse; returns in the cycle after it
    task automatic complete(input logic [1:0] ep);
        @(posedge clk_sys);
        bm_done    <= 1'b1;
        bm_done_ep <= ep;
        @(posedge clk_sys);
        bm_done    <= 1'b0;
        bm_done_ep <= ~ep;
        #1;
    endtask
endmodule

// *** tb/uied_top_tb_top.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module uied_top_tb_top;
    import uied_pkg::*;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, bm_req, bm_valid, bm_serve, bm_use_y, bm_nak;
    logic bm_done, irq;
    logic [15:0] avs_address, bm_start;
    logic [31:0] avs_writedata, avs_readdata;
    logic [1:0]  bm_ep, bm_done_ep;
    logic [6:0]  bm_count, bm_size;
    logic [7:0]  q;
    int          failures, comparisons;

    ////////////////////////////////////////////////////////////////////////////
    // Design and far side
    uied_top i_uied_top (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .bm_req, .bm_ep, .bm_valid,
        .bm_serve, .bm_use_y, .bm_nak, .bm_count, .bm_size, .bm_start, .bm_done, .bm_done_ep, .irq);
    uied_bm_model i_uied_bm_model (.clk_sys, .bm_req, .bm_ep, .bm_done, .bm_done_ep);

    // Clock
    always #5 clk_sys = ~clk_sys;

    // One bus cycle, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= wr;
        avs_read      <= !wr;
        #1;
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 50) begin
            failures++;
            $display("BAD %0t bus wait timed out", $time);
        end
        @(posedge clk_sys);
        q = avs_readdata[7:0];
        avs_write   <= 1'b0;
        avs_read    <= 1'b0;
        avs_address <= ~a;
    endtask

    // Lookup and compare every answer field
    task automatic look(input logic [1:0] ep, input int gap, input logic [32:0] e);
        i_uied_bm_model.lookup(ep, gap);
        `CHK({bm_valid, bm_serve, bm_use_y, bm_nak, bm_count, bm_size, bm_start}, {1'b1, e})
    endtask

    // Reset values and an unmapped place
    task automatic t_reset_vals();
        bus(0, EP0_IN_CFG_IDX, 0);  `CHK(q, 8'h00)
        bus(0, EP0_IN_CNT_IDX, 0);  `CHK(q, 8'h80)
        bus(0, EP0_OUT_CFG_IDX, 0); `CHK(q, 8'h00)
        bus(0, EP0_OUT_CNT_IDX, 0); `CHK(q, 8'h80)
        bus(1, 16'h0003, 8'h5a);
        bus(0, 16'h0003, 0);        `CHK(q, 8'h00)
    endtask

    // Endpoint 1 X buffer, reserved size bit set
    task automatic t_ep1_x();
        bus(1, 16'h0008, 8'h84);
        bus(1, 16'h0009, 8'h12);
        bus(1, 16'h000a, 8'h05);
        bus(1, 16'h000d, 8'h34);
        bus(1, 16'h000e, 8'h07);
        bus(1, 16'h000f, 8'hc0);
        bus(0, 16'h0009, 0); `CHK(q, 8'h12)
        bus(0, 16'h000d, 0); `CHK(q, 8'h34)
        look(2'h1, 0, {3'b100, 7'h05, 7'h40, 16'h0090});
    endtask

    // Completion with interrupt, base untouched, clear
    task automatic t_ep1_done();
        bus(1, IRQ_ENABLE_IDX, 8'h02);
        i_uied_bm_model.complete(2'h1);
        `CHK(irq, 1'b1)
        bus(0, 16'h000a, 0);   `CHK(q, 8'h85)
        bus(0, 16'h0009, 0);   `CHK(q, 8'h12)
        bus(0, IRQ_STATUS_IDX, 0); `CHK(q, 8'h02)
        bus(1, IRQ_CLEAR_IDX, 8'h02);
        #1;
        `CHK(irq, 1'b0)
    endtask

    // Double buffering with toggle picks Y, two lookups, the second after a gap of 3
    task automatic t_double_buffer_enable();
        bus(1, 16'h0008, 8'hb4);
        look(2'h1, 0, {3'b110, 7'h07, 7'h40, 16'h01a0});
        look(2'h1, 3, {3'b110, 7'h07, 7'h40, 16'h01a0});
        i_uied_bm_model.complete(2'h1);
        bus(0, 16'h000e, 0); `CHK(q, 8'h87)
        bus(1, IRQ_CLEAR_IDX, 8'h02);
    endtask

    // Disabled endpoint and interrupt enable clear
    task automatic t_disabled();
        bus(1, 16'h0008, 8'h04);
        look(2'h1, 0, {3'b001, 7'h05, 7'h40, 16'h0090});
        i_uied_bm_model.complete(2'h1);
        `CHK(irq, 1'b0)
        bus(1, 16'h0008, 8'h80);
        i_uied_bm_model.complete(2'h1);
        bus(0, IRQ_STATUS_IDX, 0); `CHK(q, 8'h00)
    endtask

    // Endpoint 0 registers and fixed buffer
    task automatic t_ep0();
        bus(1, EP0_IN_CFG_IDX, 8'hff);
        bus(0, EP0_IN_CFG_IDX, 0); `CHK(q, EP0_CFG_WMASK)
        bus(1, EP0_IN_CNT_IDX, 8'h0a);
        look(2'h0, 1, {3'b100, 7'h08, 7'h08, EP0_IN_BUF});
        bus(1, EP0_OUT_CFG_IDX, 8'hff);
        bus(0, EP0_OUT_CFG_IDX, 0); `CHK(q, 8'h8c)
        bus(1, EP0_OUT_CNT_IDX, 8'h85);
        bus(0, EP0_OUT_CNT_IDX, 0); `CHK(q, 8'h85)
    endtask

    // Verdict
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        clk_sys = 1'b0; rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
        avs_address = 16'h0; avs_writedata = 32'h0;
        failures = 0; comparisons = 0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset_vals();
        t_ep1_x();
        t_ep1_done();
        t_double_buffer_enable();
        t_disabled();
        t_ep0();
        tally_and_finish();
    end
endmodule
